// ==== include/mbf_pkg.sv ====
// Constants and types shared by the serial request framer
package mbf_pkg;

    // Clock and line rate
    localparam int MBF_CLK_HZ = 100_000_000;
    localparam int MBF_BAUD = 9600;
    localparam int MBF_BIT_CYCLES = MBF_CLK_HZ / MBF_BAUD;

    // Character layout: start + 8 data + 1 stop before options
    localparam int MBF_CHAR_BASE_BITS = 10;
    localparam int MBF_DATA_BITS = 8;

    // Silence limits in half character times (1.5 and 3.5 chars)
    localparam int MBF_GAP_INNER_HALVES = 3;
    localparam int MBF_GAP_FRAME_HALVES = 7;

    // Frame size limits in bytes
    localparam int MBF_FRAME_MIN = 4;
    localparam int MBF_FRAME_MAX = 256;

    // Check value arithmetic
    localparam logic [15:0] MBF_CRC_INIT = 16'hFFFF;
    localparam logic [15:0] MBF_CRC_POLY = 16'hA001;

    // Recognised function codes
    localparam logic [7:0] MBF_FN_RD_RELAY = 8'h01;
    localparam logic [7:0] MBF_FN_RD_INPUT = 8'h02;
    localparam logic [7:0] MBF_FN_RD_HOLD = 8'h03;
    localparam logic [7:0] MBF_FN_FORCE_RELAY = 8'h05;
    localparam logic [7:0] MBF_FN_PRESET_MULTI = 8'h10;

    // Parity selection on the cfg_parity port
    localparam logic [1:0] MBF_PAR_NONE = 2'h0;
    localparam logic [1:0] MBF_PAR_EVEN = 2'h1;
    localparam logic [1:0] MBF_PAR_ODD = 2'h2;

    // Request buffer entry: last flag above one data byte
    localparam int MBF_SKID_W = 9;

    // Frame-level sequencer, Gray along the usual path
    typedef enum logic [1:0] {
        MBF_LISTEN = 2'b00,
        MBF_DELIVER = 2'b01,
        MBF_WAIT_RSP = 2'b11,
        MBF_TX = 2'b10
    } mbf_state_t;

    // Reply byte phase, Gray along the usual path
    typedef enum logic [2:0] {
        MBF_PH_ADDR = 3'b000,
        MBF_PH_FUNC = 3'b001,
        MBF_PH_DATA = 3'b011,
        MBF_PH_CRCL = 3'b010,
        MBF_PH_CRCH = 3'b110,
        MBF_PH_DONE = 3'b111
    } mbf_phase_t;

endpackage

// ==== tb/mbf_master_model.sv ====
// Serial master model: sends request frames and captures reply characters
module mbf_master_model (
    // Clock and serial line
    input wire logic ref_clk,
    output logic rxd,
    input wire logic txd,
    input wire logic tx_drive
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam int B = 16;
    initial rxd = 1'b1;

    // Reflected check value, so the low byte leaves first
    function automatic logic [15:0] crc16(input logic [7:0] q[$]);
        logic [15:0] c;
        c = 16'hFFFF;
        foreach (q[i]) begin
            c = c ^ {8'h00, q[i]};
            for (int k = 0; k < 8; k++) begin
                c = c[0] ? (c >> 1) ^ 16'hA001 : c >> 1;
            end
        end
        return c;
    endfunction

    // Characters back to back, so no inner gap can spoil the frame
    task automatic put_frame(input logic [7:0] q[$], input bit spoil);
        logic [15:0] c;
        logic [9:0] f;
        c = crc16(q) ^ {15'h0000, spoil};
        q.push_back(c[7:0]);
        q.push_back(c[15:8]);
        foreach (q[i]) begin
            f = {1'b1, q[i], 1'b0};
            for (int k = 0; k < 10; k++) begin
                repeat (B) @(posedge ref_clk) rxd <= f[k];
            end
        end
    endtask

    // Samples at mid bit on the falling edge, away from txd updates
    task automatic get_byte(output logic [7:0] b, output logic ok);
        int n;
        n = 0;
        while (txd !== 1'b0 && n < 2000) begin
            @(negedge ref_clk);
            n++;
        end
        ok = (n < 2000) && (tx_drive === 1'b1);
        repeat (B / 2) @(negedge ref_clk);
        for (int i = 0; i < 8; i++) begin
            repeat (B) @(negedge ref_clk);
            b[i] = txd;
        end
        repeat (B) @(negedge ref_clk);
        ok = ok && (txd === 1'b1);
    endtask
endmodule // mbf_master_model

// ==== tb/testbench.sv ====
// Self-checking bench for the slave request framer
module testbench;
    import mbf_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk = 1'b0;
    logic nrst = 1'b0;
    logic rxd, txd, tx_drive, req_valid, req_last, rsp_ready;
    logic frame_ok, frame_err;
    logic req_ready = 1'b0;
    logic rsp_valid = 1'b0;
    logic rsp_last = 1'b0;
    logic [7:0] req_data;
    logic [7:0] rsp_data = 8'h00;
    int fail_count = 0;
    int cmp_count = 0;
    int cycles = 0;

    // Short bit time keeps every silence count small
    mbf_framer #(.BIT_CYCLES(16)) mbf_framer_i (
        .ref_clk(ref_clk), .nrst(nrst), .cfg_addr(8'h06),
        .cfg_parity(MBF_PAR_NONE), .cfg_two_stop(1'b0),
        .rxd(rxd), .txd(txd), .tx_drive(tx_drive),
        .req_valid(req_valid), .req_ready(req_ready),
        .req_data(req_data), .req_last(req_last),
        .rsp_valid(rsp_valid), .rsp_ready(rsp_ready),
        .rsp_data(rsp_data), .rsp_last(rsp_last),
        .frame_ok(frame_ok), .frame_err(frame_err));
    mbf_master_model mbf_master_model_i (.ref_clk(ref_clk), .rxd(rxd),
        .txd(txd), .tx_drive(tx_drive));

    initial forever #5 ref_clk = ~ref_clk;

    // Hang guard, well above the expected run length
    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == 60000) begin
            fail_count = fail_count + 1;
            results();
        end
    end

    task automatic check8(input string nm, input logic [7:0] e, g);
        cmp_count++;
        if (g !== e) begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic check1(input string nm, input logic e, g);
        cmp_count++;
        if (g !== e) begin
            fail_count++;
            $display("MISMATCH %s expected %b seen %b", nm, e, g);
        end
    endtask

    task automatic results();
        $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // One request; a good one is drained slowly, answered and its reply read
    task automatic do_frame(input logic [7:0] a, fn, input bit bad,
                            input logic good, err);
        logic [7:0] q[$];
        logic [7:0] r[$];
        logic [7:0] b;
        logic [15:0] c;
        logic ok, e, d, fr;
        int n, m;
        q = '{a, fn, 8'h00, 8'h00, 8'h00, 8'h21};
        mbf_master_model_i.put_frame(q, bad);
        ok = 1'b0;
        e = 1'b0;
        d = 1'b0;
        for (n = 0; n < 800; n++) begin
            @(negedge ref_clk);
            ok |= (frame_ok === 1'b1);
            e |= (frame_err === 1'b1);
            d |= (tx_drive === 1'b1);
        end
        check1("frame_ok", good, ok);
        check1("frame_err", err, e);
        check1("early tx_drive", 1'b0, d);
        if (good !== 1'b1) begin
            check1("req_valid", 1'b0, req_valid);
            return;
        end
        for (int i = 1; i < 6; i++) begin
            n = 0;
            while (req_valid !== 1'b1 && n < 100) begin
                @(negedge ref_clk);
                n++;
            end
            check8("req_data", q[i], req_data);
            check1("req_last", i == 5, req_last);
            @(posedge ref_clk) req_ready <= 1'b1;
            @(posedge ref_clk) req_ready <= 1'b0;
            @(negedge ref_clk);
        end
        r = '{8'h04, 8'h40, 8'h28, 8'h51, 8'hD8};
        q = '{8'h06, fn};
        q = {q, r};
        c = mbf_master_model_i.crc16(q);
        q.push_back(c[7:0]);
        q.push_back(c[15:8]);
        fork
            begin
                @(posedge ref_clk);
                foreach (r[i]) begin
                    rsp_data <= r[i];
                    rsp_last <= (i == 4);
                    rsp_valid <= 1'b1;
                    m = 0;
                    do begin
                        @(posedge ref_clk);
                        m++;
                    end while (rsp_ready !== 1'b1 && m < 3000);
                end
                rsp_valid <= 1'b0;
            end
            foreach (q[i]) begin
                mbf_master_model_i.get_byte(b, fr);
                check8("reply byte", q[i], b);
                check1("reply framing", 1'b1, fr);
            end
        join
        repeat (20) @(negedge ref_clk);
        check1("tx_drive after reply", 1'b0, tx_drive);
    endtask

    // Reset, then good, spoiled, foreign and unknown requests in turn
    initial begin
        repeat (5) @(posedge ref_clk);
        check1("txd in reset", 1'b1, txd);
        check1("tx_drive in reset", 1'b0, tx_drive);
        nrst <= 1'b1;
        repeat (2) @(posedge ref_clk);
        do_frame(8'h06, MBF_FN_RD_HOLD, 0, 1'b1, 1'b0);
        do_frame(8'h06, MBF_FN_RD_HOLD, 1, 1'b0, 1'b1);
        do_frame(8'h01, MBF_FN_RD_HOLD, 0, 1'b0, 1'b0);
        do_frame(8'h00, MBF_FN_RD_HOLD, 0, 1'b0, 1'b0);
        do_frame(8'h06, 8'h04, 0, 1'b0, 1'b0);
        do_frame(8'h06, MBF_FN_RD_RELAY, 0, 1'b1, 1'b0);
        do_frame(8'h06, MBF_FN_RD_INPUT, 0, 1'b1, 1'b0);
        do_frame(8'h06, MBF_FN_FORCE_RELAY, 0, 1'b1, 1'b0);
        do_frame(8'h06, MBF_FN_PRESET_MULTI, 0, 1'b1, 1'b0);
        results();
    end
endmodule // testbench

// ==== verilog/mbf_framer.sv ====
// Slave-side serial request framer with check value and reply sequencing
// Notes on behaviour
// R1 - Character: start bit, 8 data bits, optional even/odd parity, 1/2 stops
// R2 - Device never transmits unprompted, only in reply to a request
// R3 - Half duplex; no transmission while a query is being received
// R4 - Frame is address, function, data bytes, then 16-bit check value
// R5 - Address is the first byte, one byte wide, values 0 to 255
// R6 - Master selects the slave through the request address byte
// R7 - Reply carries the device's own configured address
// R8 - Good request answered with same function byte, user data, fresh check
// R9 - Any error in a received frame: discard it, send nothing
// R10 - Recognised function codes are 01, 02, 03, 05 and 16
// R11 - Read request data: start register then count, high byte first
// R12 - Check covers all bytes before it, data bits only
// R13 - Check accumulator starts at all ones before the first byte
// R14 - Per byte: XOR in, eight right shifts, polynomial after a one out
// R15 - Polynomial constant is A001 hex
// R16 - Check value sent low byte first, then high byte
// R17 - Receiver recomputes check and treats a mismatch as frame error
// R18 - 3.5 char silence ends a frame; inner gap over 1.5 chars spoils it
// R19 - Only frames addressed to the configured address are processed
module mbf_framer #(
    parameter int BIT_CYCLES = mbf_pkg::MBF_BIT_CYCLES
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic nrst,
    // Configuration
    input wire logic [7:0] cfg_addr,
    input wire logic [1:0] cfg_parity,
    input wire logic cfg_two_stop,
    // Serial line
    input wire logic rxd,
    output logic txd,
    output logic tx_drive,
    // Accepted request stream: function byte then data bytes
    output logic req_valid,
    input wire logic req_ready,
    output logic [7:0] req_data,
    output logic req_last,
    // Reply data stream from the user
    input wire logic rsp_valid,
    output logic rsp_ready,
    input wire logic [7:0] rsp_data,
    input wire logic rsp_last,
    // Frame outcome pulses
    output logic frame_ok,
    output logic frame_err
);
    import mbf_pkg::*;

    localparam logic [15:0] BIT_M1 = 16'(BIT_CYCLES - 1);
    localparam logic [15:0] HALF_M1 = 16'(BIT_CYCLES / 2 - 1);

    // Check value step shared by receive and transmit
    function automatic logic [15:0] crc_byte(input logic [15:0] c_in,
                                             input logic [7:0] b);
        logic [15:0] c;
        c = c_in ^ {8'h00, b}; // R12
        for (int i = 0; i < MBF_DATA_BITS; i++) begin
            c = c[0] ? ((c >> 1) ^ MBF_CRC_POLY) : (c >> 1); // R14 R15
        end
        return c;
    endfunction

    // Character format and silence thresholds from configuration
    logic par_en;
    logic par_odd;
    logic [3:0] char_bits;
    logic [23:0] t15;
    logic [23:0] t35;
    assign par_en = (cfg_parity == MBF_PAR_EVEN) || (cfg_parity == MBF_PAR_ODD);
    assign par_odd = (cfg_parity == MBF_PAR_ODD);
    assign char_bits = 4'(MBF_CHAR_BASE_BITS) + {3'h0, par_en}
                       + {3'h0, cfg_two_stop}; // R1
    assign t15 = 24'(char_bits * MBF_GAP_INNER_HALVES * (BIT_CYCLES / 2));
    assign t35 = 24'(char_bits * MBF_GAP_FRAME_HALVES * (BIT_CYCLES / 2));

    // Receiver registers
    logic rx_busy;
    logic [15:0] rx_cnt;
    logic [3:0] rx_bitn;
    logic [7:0] rx_sh;
    logic rx_err;
    logic rx_stb;
    logic rx_tick;
    logic rx_is_data;
    logic rx_is_par;
    logic rx_is_stop;
    logic rx_bad_bit;
    logic rx_last;

    // Bit classification at the sample point
    assign rx_tick = rx_busy && (rx_cnt == 16'h0000);
    assign rx_is_data = (rx_bitn != 4'h0) && (rx_bitn <= 4'h8);
    assign rx_is_par = par_en && (rx_bitn == 4'h9);
    assign rx_is_stop = (rx_bitn > 4'h8) && !rx_is_par;
    assign rx_bad_bit = rx_is_par ? (rxd != (^rx_sh ^ par_odd))
                                  : (rx_is_stop && !rxd); // R1
    assign rx_last = (rx_bitn == char_bits - 4'h1);

    // Receiver: samples mid-bit, a high start sample is a glitch
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            rx_busy <= 1'b0;
            rx_cnt <= 16'h0000;
            rx_bitn <= 4'h0;
            rx_sh <= 8'h00;
            rx_err <= 1'b0;
            rx_stb <= 1'b0;
        end else begin
            rx_stb <= rx_tick && rx_last;
            if (!rx_busy) begin
                if (!rxd) begin
                    rx_busy <= 1'b1;
                    rx_cnt <= HALF_M1;
                    rx_bitn <= 4'h0;
                    rx_err <= 1'b0;
                end
            end else if (!rx_tick) begin
                rx_cnt <= rx_cnt - 16'h0001;
            end else begin
                rx_cnt <= BIT_M1;
                rx_bitn <= rx_bitn + 4'h1;
                rx_err <= rx_err | rx_bad_bit;
                if (rx_is_data) begin
                    rx_sh <= {rxd, rx_sh[7:1]}; // R1
                end
                if ((rx_bitn == 4'h0 && rxd) || rx_last) begin
                    rx_busy <= 1'b0;
                end
            end
        end
    end

    // Frame assembly registers
    mbf_state_t state;
    mbf_state_t next_state;
    logic [7:0] frame_buf [0:MBF_FRAME_MAX-1];
    logic in_frame;
    logic f_skip;
    logic f_bad;
    logic [8:0] f_cnt;
    logic [23:0] gap_cnt;
    logic [15:0] crc_run;
    logic [15:0] crc_prev1;
    logic [15:0] crc_prev2;
    logic [7:0] last1;
    logic [7:0] last2;
    logic [7:0] rx_addr;
    logic [7:0] rx_func;
    logic eof;
    logic fn_known;
    logic f_sound;
    logic accept;
    logic [15:0] crc_start;

    // End of frame and evaluation of the finished frame
    assign eof = in_frame && !rx_busy && (gap_cnt >= t35); // R18
    assign fn_known = (rx_func == MBF_FN_RD_RELAY)
                   || (rx_func == MBF_FN_RD_INPUT)
                   || (rx_func == MBF_FN_RD_HOLD)
                   || (rx_func == MBF_FN_FORCE_RELAY)
                   || (rx_func == MBF_FN_PRESET_MULTI); // R10
    assign f_sound = !f_bad && (f_cnt >= 9'(MBF_FRAME_MIN))
                  && (crc_prev2 == {last1, last2}); // R17
    assign accept = eof && !f_skip && (state == MBF_LISTEN) && f_sound
                 && (rx_addr == cfg_addr) && fn_known; // R19
    assign crc_start = in_frame ? crc_run : MBF_CRC_INIT; // R13

    // Frame collection; a frame that starts while busy is skipped whole
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            in_frame <= 1'b0;
            f_skip <= 1'b0;
            f_bad <= 1'b0;
            f_cnt <= 9'h000;
            gap_cnt <= 24'h00_0000;
            crc_run <= MBF_CRC_INIT;
            crc_prev1 <= MBF_CRC_INIT;
            crc_prev2 <= MBF_CRC_INIT;
            last1 <= 8'h00;
            last2 <= 8'h00;
            rx_addr <= 8'h00;
            rx_func <= 8'h00;
        end else if (rx_stb) begin
            in_frame <= 1'b1;
            gap_cnt <= 24'h00_0000;
            crc_run <= crc_byte(crc_start, rx_sh); // R12 R13
            crc_prev1 <= crc_start;
            crc_prev2 <= crc_prev1;
            last1 <= rx_sh;
            last2 <= last1;
            if (!in_frame) begin
                f_skip <= (state != MBF_LISTEN);
                f_bad <= rx_err;
                f_cnt <= 9'h001;
                rx_addr <= rx_sh; // R5
            end else begin
                // Over-long inner gap or overflow spoils the frame
                f_bad <= f_bad | rx_err | (gap_cnt > t15)
                       | (f_cnt == 9'(MBF_FRAME_MAX)); // R18
                f_cnt <= f_cnt + 9'h001;
                if (f_cnt == 9'h001) begin
                    rx_func <= rx_sh; // R4
                end
            end
        end else begin
            if (!rx_busy && gap_cnt != 24'hFF_FFFF) begin
                gap_cnt <= gap_cnt + 24'h00_0001;
            end
            if (eof) begin
                in_frame <= 1'b0;
            end
        end
    end

    // Store bytes of the frame being listened to
    always_ff @(posedge ref_clk) begin
        if (rx_stb && f_cnt != 9'(MBF_FRAME_MAX)
            && (in_frame ? !f_skip : state == MBF_LISTEN)) begin
            frame_buf[in_frame ? f_cnt[7:0] : 8'h00] <= rx_sh;
        end
    end

    // Request delivery into the two-entry buffer
    logic [7:0] rd_idx;
    logic [7:0] last_idx;
    logic dlv_valid;
    logic dlv_ready;
    logic dlv_push;
    logic dlv_last;
    assign last_idx = f_cnt[7:0] - 8'h03; // R11
    assign dlv_valid = (state == MBF_DELIVER);
    assign dlv_push = dlv_valid && dlv_ready;
    assign dlv_last = (rd_idx == last_idx);

    mbf_skid u_req_buf (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .in_valid(dlv_valid),
        .in_ready(dlv_ready),
        .in_data({dlv_last, frame_buf[rd_idx]}),
        .out_valid(req_valid),
        .out_ready(req_ready),
        .out_data({req_last, req_data})
    );

    // Transmitter and reply sequencing
    mbf_phase_t phase;
    logic tx_busy;
    logic [15:0] tx_cnt;
    logic [3:0] tx_bitn;
    logic [11:0] tx_sh;
    logic [15:0] crc_tx;
    logic rsp_take;
    logic tx_load;
    logic [7:0] tx_byte;
    logic tx_fixed;
    logic tx_end;
    logic next_rsp_ready;

    assign rsp_take = rsp_valid && rsp_ready;
    assign tx_fixed = (phase == MBF_PH_ADDR) || (phase == MBF_PH_FUNC)
                   || (phase == MBF_PH_CRCL) || (phase == MBF_PH_CRCH);
    assign tx_load = (state == MBF_TX) && !tx_busy && (tx_fixed || rsp_take);
    assign tx_byte = (phase == MBF_PH_ADDR) ? cfg_addr // R7
                   : (phase == MBF_PH_FUNC) ? rx_func // R8
                   : (phase == MBF_PH_CRCL) ? crc_tx[7:0] // R16
                   : (phase == MBF_PH_CRCH) ? crc_tx[15:8] : rsp_data;
    assign tx_end = (state == MBF_TX) && (phase == MBF_PH_DONE) && !tx_busy;
    assign next_rsp_ready = (state == MBF_TX) && (phase == MBF_PH_DATA)
                         && !tx_busy && !rsp_take;

    // Sequencer: reply only after an accepted request and a quiet line
    always_comb begin
        next_state = state;
        case (state)
            MBF_LISTEN: begin
                if (accept) begin
                    next_state = MBF_DELIVER; // R2 R19
                end
            end
            MBF_DELIVER: begin
                if (dlv_push && dlv_last) begin
                    next_state = MBF_WAIT_RSP;
                end
            end
            MBF_WAIT_RSP: begin
                if (!in_frame && !rx_busy) begin
                    next_state = MBF_TX; // R3
                end
            end
            default: begin
                if (tx_end) begin
                    next_state = MBF_LISTEN;
                end
            end
        endcase
    end

    // Sequencer state, read index, reply phase and outcome pulses
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            state <= MBF_LISTEN;
            rd_idx <= 8'h01;
            phase <= MBF_PH_ADDR;
            crc_tx <= MBF_CRC_INIT;
            rsp_ready <= 1'b0;
            tx_drive <= 1'b0;
            frame_ok <= 1'b0;
            frame_err <= 1'b0;
        end else begin
            state <= next_state;
            rsp_ready <= next_rsp_ready;
            tx_drive <= (next_state == MBF_TX); // R2
            frame_ok <= accept;
            // Spoiled frames vanish silently apart from this pulse
            frame_err <= eof && !f_skip && (state == MBF_LISTEN)
                      && !f_sound; // R9 R17
            if (state == MBF_LISTEN) begin
                rd_idx <= 8'h01;
                phase <= MBF_PH_ADDR;
                crc_tx <= MBF_CRC_INIT; // R13
            end
            if (dlv_push && !dlv_last) begin
                rd_idx <= rd_idx + 8'h01;
            end
            if (tx_load) begin
                // Check value freezes once its own two bytes go out
                if (phase != MBF_PH_CRCL && phase != MBF_PH_CRCH) begin
                    crc_tx <= crc_byte(crc_tx, tx_byte); // R12 R14
                end
                case (phase)
                    MBF_PH_ADDR: phase <= MBF_PH_FUNC;
                    MBF_PH_FUNC: phase <= MBF_PH_DATA;
                    MBF_PH_DATA: phase <= rsp_last ? MBF_PH_CRCL : MBF_PH_DATA;
                    MBF_PH_CRCL: phase <= MBF_PH_CRCH; // R16
                    default: phase <= MBF_PH_DONE;
                endcase
            end
        end
    end

    // Character shifter; the line idles high between characters
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            tx_busy <= 1'b0;
            tx_cnt <= 16'h0000;
            tx_bitn <= 4'h0;
            tx_sh <= 12'hFFF;
            txd <= 1'b1;
        end else if (tx_load) begin
            tx_busy <= 1'b1;
            tx_cnt <= BIT_M1;
            tx_bitn <= 4'h0;
            tx_sh <= {2'b11, par_en ? (^tx_byte ^ par_odd) : 1'b1,
                      tx_byte, 1'b0}; // R1
            txd <= 1'b0;
        end else if (tx_busy) begin
            if (tx_cnt != 16'h0000) begin
                tx_cnt <= tx_cnt - 16'h0001;
            end else if (tx_bitn == char_bits - 4'h1) begin
                tx_busy <= 1'b0;
            end else begin
                tx_cnt <= BIT_M1;
                tx_bitn <= tx_bitn + 4'h1;
                tx_sh <= {1'b1, tx_sh[11:1]};
                txd <= tx_sh[1];
            end
        end
    end

    // Checks on the design's own behaviour
    property p_no_tx_in_query;
        @(posedge ref_clk) disable iff (!nrst)
        $rose(tx_drive) |-> !in_frame && !rx_busy;
    endproperty
    a_no_tx_in_query: assert property (p_no_tx_in_query) // R3
        else $error("reply started during a query");
    property p_tx_only_reply;
        @(posedge ref_clk) disable iff (!nrst)
        $rose(tx_drive) |-> $past(state) == MBF_WAIT_RSP;
    endproperty
    a_tx_only_reply: assert property (p_tx_only_reply) // R2
        else $error("transmission without a request");
    property p_err_silent;
        @(posedge ref_clk) disable iff (!nrst)
        frame_err |-> state == MBF_LISTEN && !tx_drive;
    endproperty
    a_err_silent: assert property (p_err_silent) // R9
        else $error("spoiled frame led to activity");
    property p_crc_seed;
        @(posedge ref_clk) disable iff (!nrst)
        (rx_stb && !in_frame && rx_sh == 8'h00) |=> crc_run == 16'h40BF;
    endproperty
    a_crc_seed: assert property (p_crc_seed) // R13
        else $error("check value seed or step wrong");
    property p_crc_poly;
        @(posedge ref_clk) disable iff (!nrst)
        (rx_stb && !in_frame && rx_sh == 8'h01) |=> crc_run == 16'h807E;
    endproperty
    a_crc_poly: assert property (p_crc_poly) // R14
        else $error("check value polynomial wrong");
    property p_own_addr;
        @(posedge ref_clk) disable iff (!nrst)
        (tx_load && phase == MBF_PH_ADDR) |=> !txd && tx_sh[8:1] == cfg_addr;
    endproperty
    a_own_addr: assert property (p_own_addr) // R7
        else $error("reply address is not the configured one");
    property p_crc_low_first;
        @(posedge ref_clk) disable iff (!nrst)
        (tx_load && phase == MBF_PH_CRCL) |=> tx_sh[8:1] == $past(crc_tx[7:0]);
    endproperty
    a_crc_low_first: assert property (p_crc_low_first) // R16
        else $error("check value low byte not sent first");
    property p_crc_high_second;
        @(posedge ref_clk) disable iff (!nrst)
        (tx_load && phase == MBF_PH_CRCH) |=>
            tx_sh[8:1] == $past(crc_tx[15:8]);
    endproperty
    a_crc_high_second: assert property (p_crc_high_second) // R16
        else $error("check value high byte not sent second");
    property p_addr_match;
        @(posedge ref_clk) disable iff (!nrst)
        frame_ok |-> $past(rx_addr) == $past(cfg_addr) && $past(f_sound);
    endproperty
    a_addr_match: assert property (p_addr_match) // R17 R19
        else $error("frame accepted without match or sound check");
    property p_start_bit;
        @(posedge ref_clk) disable iff (!nrst)
        tx_load |=> !txd [*8];
    endproperty
    a_start_bit: assert property (p_start_bit) // R1
        else $error("start bit not held low");
    c_accept: cover property (@(posedge ref_clk) disable iff (!nrst) frame_ok);
    c_reject: cover property (@(posedge ref_clk) disable iff (!nrst) frame_err);
    c_reply_done: cover property (@(posedge ref_clk) disable iff (!nrst)
        tx_end);

endmodule // mbf_framer

// ==== verilog/mbf_skid.sv ====
// Two-entry buffer with valid and ready on both sides
module mbf_skid (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic nrst,
    // Filling side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [mbf_pkg::MBF_SKID_W-1:0] in_data,
    // Draining side
    output logic out_valid,
    input wire logic out_ready,
    output logic [mbf_pkg::MBF_SKID_W-1:0] out_data
);
    import mbf_pkg::*;

    logic tail_valid;
    logic [MBF_SKID_W-1:0] tail;
    logic push;
    logic pop;
    logic head_free;

    // Handshakes; the head slot frees when empty or being drained
    assign in_ready = !tail_valid;
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    assign head_free = !out_valid || pop;

    // Head feeds the port straight from a flop, tail absorbs a stall
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            out_valid <= 1'b0;
            out_data <= '0;
            tail_valid <= 1'b0;
            tail <= '0;
        end else if (head_free) begin
            if (tail_valid) begin
                out_data <= tail;
                out_valid <= 1'b1;
                tail_valid <= push;
                if (push) begin
                    tail <= in_data;
                end
            end else begin
                out_data <= in_data;
                out_valid <= push;
            end
        end else if (push) begin
            tail <= in_data;
            tail_valid <= 1'b1;
        end
    end

endmodule // mbf_skid
